// *** tdm_slot_loop_switch.sv ***
// time-slot switch with loop paths, single-frame buffers and access registers
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
// Operation
// - First connection stores a downstream PCM pointer in downstream control of the slot.
// - Mode codes 0001 to 0111 also drive looped data on the subscriber output pin.
// - Mode code 0000 keeps the subscriber output pin undriven for the looped slot.
// - Leading-zero upstream pointer takes slot input from internal downstream serial output.
// - Leading-zero upstream pointer still selects an upstream PCM slot as destination.
// - Subscriber-PCM-subscriber loop reads subscriber data from upstream data memory.
// - Only one frame of slot data is held per direction.
// - Close or earlier output slots receive data one frame later.
// - Serial slot input is made parallel before being stored.
// - Data memory is written only at the end-of-slot write interval.
// - Output slots are read in parallel at the slot read cycle, then serialised.
// - Read after write in the same frame passes data with zero frame delay.
// - Read before write sends the previous frame's value.
// - Control 0110 0000 writes a PCM transmit slot's drive field, one bit per pair of bits.
// - Control upper nibble 0111 stores a connection with the lower nibble as mode.
// - Subscriber loops use a spare PCM slot whose drive may stay high impedance.
module tdm_slot_loop_switch #(
  parameter int NUM_SLOTS = 32,
  parameter int BIT_DIV   = tdm_loop_pkg::BIT_DIV
) (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       frame_sync,
  input  wire logic       pcm_rx,
  output logic            pcm_tx,
  output logic            pcm_tx_oe,
  input  wire logic       sub_rx,
  output logic            sub_tx,
  output logic            sub_tx_oe
);
  localparam int SLOT_W = (NUM_SLOTS > 1) ? $clog2(NUM_SLOTS) : 1;
  localparam int DIV_W  = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;
  localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(BIT_DIV - 1);
  localparam logic [DIV_W-1:0]  DIV_HALF  = DIV_W'(BIT_DIV / 2); // frame restart phase
  localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(NUM_SLOTS - 1);

  // one register set holds all memories, so each direction keeps exactly one frame
  typedef struct packed {
    logic [NUM_SLOTS-1:0][7:0] dn_data_mem;   // downstream PCM slots received
    logic [NUM_SLOTS-1:0][7:0] up_data_mem;   // upstream PCM slots to send
    logic [NUM_SLOTS-1:0][7:0] dn_conn_ptr;   // per subscriber slot, downstream source
    logic [NUM_SLOTS-1:0][7:0] up_conn_ptr;   // per subscriber slot, upstream destination
    logic [NUM_SLOTS-1:0][3:0] dn_conn_mode;
    logic [NUM_SLOTS-1:0][3:0] up_conn_mode;
    logic [NUM_SLOTS-1:0][3:0] tx_drive_mask; // one bit per pair of PCM bits
    logic [7:0]                access_data;
    logic [7:0]                access_addr;
    logic [7:0]                access_ctrl;
    logic [7:0]                rdata;
    logic [DIV_W-1:0]          div;
    logic [2:0]                bit_idx;
    logic [SLOT_W-1:0]         slot;
    logic [7:0]                pcm_rx_sh;
    logic [7:0]                sub_rx_sh;
    logic [7:0]                pcm_word;
    logic [7:0]                sub_word;
    logic [3:0]                pcm_mask;
    logic [3:0]                sub_mode;
    logic                      fs_prev;
    logic                      pcm_bit;
    logic                      pcm_oe;
    logic                      sub_bit;
    logic                      sub_oe;
  } sw_state_t;

  sw_state_t s_r;
  sw_state_t s_nxt;

  logic              fs_stable;
  logic              pcm_rx_s;
  logic              sub_rx_s;
  logic              fs_rise;
  logic              bit_tick;
  logic              slot_end;
  logic [SLOT_W-1:0] next_slot;
  logic [SLOT_W-1:0] acc_slot;
  logic              ctrl_wr;
  logic              conn_op;
  logic              tri_op;
  logic [7:0]        up_ptr_cur;
  logic [3:0]        up_mode_cur;
  logic              dn_serial_bit;
  logic              up_in_bit;
  logic [7:0]        pcm_in_word;
  logic [7:0]        up_in_word;
  logic [7:0]        dn_ptr_next;
  logic [3:0]        dn_mode_next;
  logic [7:0]        sub_read_word;
  logic [7:0]        pcm_read_word;

  // ==========================================================
  // pin synchronisers
  pin_sync3 u_sync_fs (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .pin_in     (frame_sync),
    .pin_stable (fs_stable)
  );
  pin_sync3 u_sync_pcm (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .pin_in     (pcm_rx),
    .pin_stable (pcm_rx_s)
  );
  pin_sync3 u_sync_sub (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .pin_in     (sub_rx),
    .pin_stable (sub_rx_s)
  );

  // ==========================================================
  // slot timing and memory access decode
  always_comb begin
    fs_rise     = fs_stable && !s_r.fs_prev;
    bit_tick    = (s_r.div == DIV_LAST) && !fs_rise;  // frame start wins over a tick
    slot_end    = bit_tick && (s_r.bit_idx == tdm_loop_pkg::SLOT_LSB_BIT);
    next_slot   = (s_r.slot == SLOT_LAST) ? '0 : s_r.slot + 1'b1;
    acc_slot    = s_r.access_addr[SLOT_W-1:0];
    ctrl_wr     = reg_wr && (reg_addr == tdm_loop_pkg::OFS_ACCESS_CTRL);
    conn_op     = ctrl_wr && (reg_wdata[7:4] == tdm_loop_pkg::MEM_OP_CONN);
    tri_op      = ctrl_wr && (reg_wdata == tdm_loop_pkg::MEM_OP_TRISTATE);
    up_ptr_cur  = s_r.up_conn_ptr[s_r.slot];
    up_mode_cur = s_r.up_conn_mode[s_r.slot];
    // the internal downstream serial bit exists even when the pin is quiet
    dn_serial_bit = s_r.sub_word[s_r.bit_idx];
    // loop switch: a leading zero pointer replaces the pin by the internal stream
    up_in_bit   = (up_ptr_cur[tdm_loop_pkg::DIR_BIT] == tdm_loop_pkg::LOOP_SWITCH) ?
                  dn_serial_bit : sub_rx_s;
    pcm_in_word = {s_r.pcm_rx_sh[6:0], pcm_rx_s};
    up_in_word  = {s_r.sub_rx_sh[6:0], up_in_bit};
    dn_ptr_next  = s_r.dn_conn_ptr[next_slot];
    dn_mode_next = s_r.dn_conn_mode[next_slot];
    // a pointer with the up bit fetches from upstream memory: subscriber loop path
    sub_read_word = (dn_ptr_next[tdm_loop_pkg::DIR_BIT] == tdm_loop_pkg::DIR_UP) ?
                    s_r.up_data_mem[dn_ptr_next[SLOT_W-1:0]] :
                    s_r.dn_data_mem[dn_ptr_next[SLOT_W-1:0]];
    pcm_read_word = s_r.up_data_mem[next_slot];
  end

  // ==========================================================
  // next state: serial shifting, memory access cycles, register port
  always_comb begin
    s_nxt         = s_r;
    s_nxt.fs_prev = fs_stable;
    s_nxt.rdata   = tdm_loop_pkg::REG_RST;
    // slot counters
    if (fs_rise) begin
      // restart mid-bit: input samples land mid-bit and the last tick of a frame
      // never meets the pulse of the next one, which would cancel that slot end
      s_nxt.div     = DIV_HALF;
      s_nxt.bit_idx = tdm_loop_pkg::SLOT_MSB_BIT;
      s_nxt.slot    = '0;
    end else if (bit_tick) begin
      s_nxt.div     = '0;
      s_nxt.bit_idx = s_r.bit_idx - 1'b1;
      s_nxt.pcm_rx_sh = pcm_in_word;
      s_nxt.sub_rx_sh = up_in_word;
      if (slot_end) begin
        s_nxt.slot = next_slot;
        // write interval: a downstream store at the close of each slot, an upstream store only if the slot is assigned
        s_nxt.dn_data_mem[s_r.slot] = pcm_in_word;
        if (up_mode_cur != tdm_loop_pkg::MODE_UNASSIGNED) begin
          s_nxt.up_data_mem[up_ptr_cur[SLOT_W-1:0]] = up_in_word;
        end
        // read cycle uses the old memory, so a same-edge store goes out next frame
        s_nxt.sub_word = sub_read_word;
        s_nxt.sub_mode = dn_mode_next;
        s_nxt.pcm_word = pcm_read_word;
        s_nxt.pcm_mask = s_r.tx_drive_mask[next_slot];
      end
    end else begin
      s_nxt.div = s_r.div + 1'b1;
    end
    // register port; writes to the three access registers, control starts an op
    if (reg_wr) begin
      case (reg_addr)
        tdm_loop_pkg::OFS_ACCESS_DATA: begin
          s_nxt.access_data = reg_wdata;
        end
        tdm_loop_pkg::OFS_ACCESS_ADDR: begin
          s_nxt.access_addr = reg_wdata;
        end
        tdm_loop_pkg::OFS_ACCESS_CTRL: begin
          s_nxt.access_ctrl = reg_wdata;
        end
        default: begin
        end
      endcase
    end
    if (conn_op) begin
      // direction bit of the address picks which control half is written
      if (s_r.access_addr[tdm_loop_pkg::DIR_BIT] == tdm_loop_pkg::DIR_UP) begin
        s_nxt.up_conn_ptr[acc_slot]  = s_r.access_data;
        s_nxt.up_conn_mode[acc_slot] = reg_wdata[3:0];
      end else begin
        s_nxt.dn_conn_ptr[acc_slot]  = s_r.access_data;
        s_nxt.dn_conn_mode[acc_slot] = reg_wdata[3:0];
      end
    end else if (tri_op) begin
      s_nxt.tx_drive_mask[acc_slot] = s_r.access_data[3:0];
    end
    if (reg_rd) begin
      case (reg_addr)
        tdm_loop_pkg::OFS_ACCESS_DATA: s_nxt.rdata = s_r.access_data;
        tdm_loop_pkg::OFS_ACCESS_ADDR: s_nxt.rdata = s_r.access_addr;
        tdm_loop_pkg::OFS_ACCESS_CTRL: s_nxt.rdata = s_r.access_ctrl;
        tdm_loop_pkg::OFS_STATUS:      s_nxt.rdata = 8'(s_r.slot);
        default:                       s_nxt.rdata = tdm_loop_pkg::REG_RST;
      endcase
    end
    // serialisers: output bits come from the words loaded at the read cycle
    s_nxt.pcm_bit = s_nxt.pcm_word[s_nxt.bit_idx];
    s_nxt.pcm_oe  = s_nxt.pcm_mask[s_nxt.bit_idx[2:1]];
    s_nxt.sub_bit = s_nxt.sub_word[s_nxt.bit_idx];
    s_nxt.sub_oe  = (s_nxt.sub_mode != tdm_loop_pkg::MODE_UNASSIGNED);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r         <= '0;
      s_r.bit_idx <= tdm_loop_pkg::SLOT_MSB_BIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign pcm_tx    = s_r.pcm_bit;
  assign pcm_tx_oe = s_r.pcm_oe;
  assign sub_tx    = s_r.sub_bit;
  assign sub_tx_oe = s_r.sub_oe;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence quiet_slot_s;
    !sub_tx_oe [*8];
  endsequence

  a_quiet_unassigned: assert property (
    slot_end && (dn_mode_next == tdm_loop_pkg::MODE_UNASSIGNED) |=> quiet_slot_s)
    else $error("subscriber output driven for unassigned slot");

  a_drive_assigned: assert property (
    slot_end && (dn_mode_next != tdm_loop_pkg::MODE_UNASSIGNED) |=> sub_tx_oe)
    else $error("subscriber output not driven for assigned slot");

  a_tristate_store: assert property (
    tri_op |=> s_r.tx_drive_mask[$past(acc_slot)] == $past(s_r.access_data[3:0]))
    else $error("drive field not stored");

  a_conn_store_dn: assert property (
    conn_op && (s_r.access_addr[tdm_loop_pkg::DIR_BIT] == tdm_loop_pkg::DIR_DOWN)
    |=> s_r.dn_conn_mode[$past(acc_slot)] == $past(reg_wdata[3:0]))
    else $error("downstream mode not stored");

  a_loop_source: assert property (
    bit_tick && (up_ptr_cur[tdm_loop_pkg::DIR_BIT] == tdm_loop_pkg::LOOP_SWITCH)
    |=> s_r.sub_rx_sh[0] == $past(dn_serial_bit))
    else $error("loop slot did not take internal stream");

  a_up_destination: assert property (
    slot_end && (up_mode_cur != tdm_loop_pkg::MODE_UNASSIGNED)
    |=> s_r.up_data_mem[$past(up_ptr_cur[SLOT_W-1:0])] == $past(up_in_word))
    else $error("upstream word not stored at pointer");

  a_sub_from_up: assert property (
    slot_end && (dn_ptr_next[tdm_loop_pkg::DIR_BIT] == tdm_loop_pkg::DIR_UP)
    |=> s_r.sub_word == $past(sub_read_word))
    else $error("subscriber loop word not from upstream memory");

  a_write_window: assert property (
    !slot_end |=> s_r.dn_data_mem == $past(s_r.dn_data_mem))
    else $error("data memory written outside write interval");

  a_pcm_read_old: assert property (
    slot_end |=> s_r.pcm_word == $past(pcm_read_word) ##1 pcm_tx == s_r.pcm_word[7])
    else $error("pcm read cycle wrong");

  a_conn_store_up: assert property (
    conn_op && (s_r.access_addr[tdm_loop_pkg::DIR_BIT] == tdm_loop_pkg::DIR_UP)
    |=> s_r.up_conn_ptr[$past(acc_slot)] == $past(s_r.access_data))
    else $error("upstream pointer not stored");

  a_dn_store: assert property (
    slot_end |=> s_r.dn_data_mem[$past(s_r.slot)] == $past(pcm_in_word))
    else $error("received pcm word not stored in its slot");

  a_drive_load: assert property (
    slot_end |=> s_r.pcm_mask == $past(s_r.tx_drive_mask[next_slot]))
    else $error("drive field not loaded for next slot");
endmodule // tdm_slot_loop_switch

// *** tdm_loop_pkg.sv ***
// constants shared by the slot loop switch and its bench
package tdm_loop_pkg;
  // ==========================================================
  // register offsets on the plain access port
  localparam logic [1:0] OFS_ACCESS_DATA = 2'h0;
  localparam logic [1:0] OFS_ACCESS_ADDR = 2'h1;
  localparam logic [1:0] OFS_ACCESS_CTRL = 2'h2;
  localparam logic [1:0] OFS_STATUS      = 2'h3;
  localparam logic [7:0] REG_RST         = 8'h00;

  // ==========================================================
  // memory operation codes and field layout
  localparam logic [3:0] MEM_OP_CONN     = 4'h7;  // upper nibble: store a connection
  localparam logic [7:0] MEM_OP_TRISTATE = 8'h60; // whole byte: tristate field access
  localparam logic [3:0] MODE_UNASSIGNED = 4'h0;
  localparam int         DIR_BIT         = 7;     // direction bit in address and pointer
  localparam logic       DIR_DOWN        = 1'b0;
  localparam logic       DIR_UP          = 1'b1;
  localparam logic       LOOP_SWITCH     = 1'b0;  // leading pointer bit that selects the loop
  localparam logic [2:0] SLOT_MSB_BIT    = 3'h7;
  localparam logic [2:0] SLOT_LSB_BIT    = 3'h0;

  // ==========================================================
  // timing
  localparam int CLK_HZ      = 40_000_000;
  localparam int BIT_RATE_HZ = 2_048_000;
  localparam int BIT_DIV     = CLK_HZ / BIT_RATE_HZ; // sys_clk cycles per serial bit
endpackage

// *** pin_sync3.sv ***
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_sync3 (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic pin_in,
  output logic      pin_stable
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic stable;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  // ==========================================================
  // stage one feeds stage two only; the filter looks at two and three
  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = pin_in;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    if (s_r.s2 == s_r.s3) begin
      s_nxt.stable = s_r.s2;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pin_stable = s_r.stable;
endmodule // pin_sync3

// *** tdm_far_end.sv ***
// far-end model: pcm highway and subscriber devices around the switch
`timescale 1ns/1ps
module tdm_far_end #(
  parameter int NUM_SLOTS = 8,
  parameter int BIT_DIV   = 8,
  parameter int OUT_OFS   = 5
) (
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  input  wire logic [NUM_SLOTS-1:0][7:0] pcm_src,
  input  wire logic [NUM_SLOTS-1:0][7:0] sub_src,
  input  wire logic                      pcm_tx,
  input  wire logic                      pcm_tx_oe,
  input  wire logic                      sub_tx,
  input  wire logic                      sub_tx_oe,
  output logic                           frame_sync,
  output logic                           pcm_rx,
  output logic                           sub_rx,
  output logic                           frame_start,
  output logic                           res_valid,
  output logic [7:0]                     res_slot,
  output logic [7:0]                     res_pcm,
  output logic [7:0]                     res_pcm_oe,
  output logic [7:0]                     res_sub,
  output logic [7:0]                     res_sub_oe
);
  localparam int SLOT_LEN  = 8 * BIT_DIV;
  localparam int FRAME_LEN = NUM_SLOTS * SLOT_LEN;
  int         cnt_r;
  int         ocnt_r;
  logic [7:0] sh_p_r, sh_po_r, sh_s_r, sh_so_r;
  logic       pcm_line, sub_line;

  // an undriven line shows the inverse, so a released pin never passes as data
  assign pcm_line = pcm_tx_oe ? pcm_tx : ~pcm_tx;
  assign sub_line = sub_tx_oe ? sub_tx : ~sub_tx;

  // ==========================================================
  // frame timing: bits start at the frame_sync rise, msb first
  assign frame_sync  = (cnt_r < 4);
  assign frame_start = (cnt_r == 0);
  assign pcm_rx = pcm_src[cnt_r / SLOT_LEN][7 - (cnt_r / BIT_DIV) % 8];
  assign sub_rx = sub_src[cnt_r / SLOT_LEN][7 - (cnt_r / BIT_DIV) % 8];

  // output sampling lags by the switch's sync delay, landing mid-bit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= 0;
      ocnt_r <= FRAME_LEN - OUT_OFS;
    end else begin
      cnt_r  <= (cnt_r == FRAME_LEN - 1) ? 0 : cnt_r + 1;
      ocnt_r <= (ocnt_r == FRAME_LEN - 1) ? 0 : ocnt_r + 1;
    end
  end

  // ==========================================================
  // receiver: one whole byte per slot, reported at its last bit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      res_valid <= 1'b0;
    end else begin
      res_valid <= (ocnt_r % BIT_DIV == 0) && ((ocnt_r / BIT_DIV) % 8 == 7);
    end
  end

  // drive enables are sampled per bit so a partial mask shows up
  always_ff @(posedge sys_clk) begin
    if (ocnt_r % BIT_DIV == 0) begin
      sh_p_r     <= {sh_p_r[6:0], pcm_line};
      sh_po_r    <= {sh_po_r[6:0], pcm_tx_oe};
      sh_s_r     <= {sh_s_r[6:0], sub_line};
      sh_so_r    <= {sh_so_r[6:0], sub_tx_oe};
      res_slot   <= 8'(ocnt_r / SLOT_LEN);
      res_pcm    <= {sh_p_r[6:0], pcm_line};
      res_pcm_oe <= {sh_po_r[6:0], pcm_tx_oe};
      res_sub    <= {sh_s_r[6:0], sub_line};
      res_sub_oe <= {sh_so_r[6:0], sub_tx_oe};
    end
  end
endmodule // tdm_far_end

// *** tdm_slot_loop_switching_tb.sv ***
// self-checking bench for the slot loop switch
`timescale 1ns/1ps
module tdm_slot_loop_switching_tb;
  localparam int         NS = 8;
  localparam int         FL = NS * 64;
  localparam logic [7:0] SA = 8'h01, SS = 8'h03, SB = 8'h06;
  localparam logic       DN = tdm_loop_pkg::DIR_DOWN, UP = tdm_loop_pkg::DIR_UP;
  localparam logic       LP = tdm_loop_pkg::LOOP_SWITCH;
  typedef struct packed {logic [7:0] slot; logic [1:0] kind; logic [7:0] val;} note_t;
  logic               sys_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0]         reg_addr = 2'h0;
  logic [7:0]         reg_wdata = 8'h00, reg_rdata;
  logic               frame_sync, pcm_rx, pcm_tx, pcm_tx_oe, sub_rx, sub_tx, sub_tx_oe;
  logic               frame_start, res_valid, rd_d = 1'b0, rd_dd = 1'b0;
  logic [7:0]         res_slot, res_pcm, res_pcm_oe, res_sub, res_sub_oe;
  logic [NS-1:0][7:0] pcm_src = '0, sub_src = '0;
  logic [31:0]        seed = 32'h00000042;
  logic [7:0]         v = 8'h00, pv = 8'h00, w = 8'h00;
  note_t              eq[$];
  logic [7:0]         rq[$];
  int                 error_cnt = 0, checks = 0;

  // clock: 25 ns period
  always #12.5 sys_clk = ~sys_clk;

  tdm_slot_loop_switch #(.NUM_SLOTS(NS), .BIT_DIV(8)) dut_u (.sys_clk(sys_clk),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_sync(frame_sync), .pcm_rx(pcm_rx),
    .pcm_tx(pcm_tx), .pcm_tx_oe(pcm_tx_oe), .sub_rx(sub_rx), .sub_tx(sub_tx),
    .sub_tx_oe(sub_tx_oe));
  tdm_far_end #(.NUM_SLOTS(NS), .BIT_DIV(8), .OUT_OFS(5)) far_u (.sys_clk(sys_clk),
    .arst_n(arst_n), .pcm_src(pcm_src), .sub_src(sub_src), .pcm_tx(pcm_tx),
    .pcm_tx_oe(pcm_tx_oe), .sub_tx(sub_tx), .sub_tx_oe(sub_tx_oe),
    .frame_sync(frame_sync), .pcm_rx(pcm_rx), .sub_rx(sub_rx), .frame_start(frame_start),
    .res_valid(res_valid), .res_slot(res_slot), .res_pcm(res_pcm), .res_pcm_oe(res_pcm_oe),
    .res_sub(res_sub), .res_sub_oe(res_sub_oe));

  // ==========================================================
  // helpers
  function logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function logic [7:0] mk(input logic d, input logic [7:0] s);
    return {d, 2'h0, s[4:0]};
  endfunction
  task cmp_slot(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t slot byte %h, expected %h", $time, got, exp);
    end
  endtask
  task cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t read data %h, expected %h", $time, got, exp);
    end
  endtask
  // strobes stay up between back-to-back accesses; idle drops them
  task wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
  endtask
  task rd(input logic [1:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    rq.push_back(exp);
    @(posedge sys_clk);
  endtask
  task idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task cx(input logic [7:0] d, input logic dir, input logic [7:0] s, input logic [3:0] m);
    wr(tdm_loop_pkg::OFS_ACCESS_DATA, d);
    wr(tdm_loop_pkg::OFS_ACCESS_ADDR, mk(dir, s));
    wr(tdm_loop_pkg::OFS_ACCESS_CTRL, {tdm_loop_pkg::MEM_OP_CONN, m});
    idle();
  endtask
  task tri_set(input logic [7:0] mask, input logic [7:0] s);
    wr(tdm_loop_pkg::OFS_ACCESS_DATA, mask);
    wr(tdm_loop_pkg::OFS_ACCESS_ADDR, mk(UP, s));
    wr(tdm_loop_pkg::OFS_ACCESS_CTRL, tdm_loop_pkg::MEM_OP_TRISTATE);
    idle();
  endtask
  task nt(input logic [7:0] s, input logic [1:0] k, input logic [7:0] val);
    eq.push_back('{slot: s, kind: k, val: val});
  endtask
  // kind 0 pcm byte, 1 pcm drive, 2 subscriber byte, 3 subscriber drive
  task run(input int sc, input int nf);
    for (int f = 0; f < nf; f++) begin
      @(posedge sys_clk);
      while (frame_start !== 1'b1) @(posedge sys_clk);
      pv = v;
      v = rnd();
      w = rnd();
      pcm_src[SA] <= v;
      sub_src <= {NS{w}};
      if (f >= 2) begin
        case (sc)
          0: for (int s = 0; s < NS; s++) begin
            nt(8'(s), 2'h1, 8'h00);
            nt(8'(s), 2'h3, 8'h00);
          end
          1: begin
            nt(SS, 2'h2, v);
            nt(SS, 2'h3, 8'hFF);
            nt(SB, 2'h0, v);
            nt(SB, 2'h1, 8'hFF);
          end
          2: begin
            nt(8'h00, 2'h0, pv);
            nt(8'h00, 2'h1, 8'hFF);
            nt(SS, 2'h3, 8'h00);
            nt(SB, 2'h1, 8'h33);
          end
          3: begin
            nt(8'h05, 2'h1, 8'h00);
            nt(SB, 2'h2, w);
            nt(SB, 2'h3, 8'hFF);
          end
          default: nt(SS, 2'h3, 8'hFF);
        endcase
      end
      // status shows the running slot; probe well inside slot three
      repeat (200) @(posedge sys_clk);
      rd(tdm_loop_pkg::OFS_STATUS, SS);
      idle();
    end
    for (int i = 0; i < FL && eq.size() > 0; i++) @(posedge sys_clk);
    if (eq.size() > 0) begin
      error_cnt++;
      $display("[FAIL] %0t %0d slot results never arrived", $time, eq.size());
      eq.delete();
    end
    $display("test %0d done", sc);
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // monitors: all notes for the slot at the queue head are taken as each result lands
  always @(posedge sys_clk) begin : slot_mon
    note_t      n;
    logic [7:0] got;
    if (res_valid === 1'b1) begin
      while (eq.size() > 0 && eq[0].slot === res_slot) begin
        n = eq.pop_front();
        case (n.kind)
          2'h0: got = res_pcm;
          2'h1: got = res_pcm_oe;
          2'h2: got = res_sub;
          default: got = res_sub_oe;
        endcase
        cmp_slot(got, n.val);
      end
    end
  end
  // read data stands one cycle after the strobe, zero afterwards
  always @(posedge sys_clk) begin : reg_mon
    if (rd_d) cmp_reg(reg_rdata, rq.pop_front());
    else if (rd_dd) cmp_reg(reg_rdata, 8'h00);
    rd_dd <= rd_d;
    rd_d <= reg_rd;
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rd(tdm_loop_pkg::OFS_ACCESS_DATA, tdm_loop_pkg::REG_RST);
    rd(tdm_loop_pkg::OFS_ACCESS_ADDR, tdm_loop_pkg::REG_RST);
    idle();
    run(0, 3);
    v = rnd();
    wr(tdm_loop_pkg::OFS_ACCESS_DATA, v);
    wr(tdm_loop_pkg::OFS_STATUS, ~v);
    rd(tdm_loop_pkg::OFS_ACCESS_DATA, v);
    idle();
    cx(mk(DN, SA), DN, SS, 4'h1);
    cx(mk(LP, SB), UP, SS, 4'h1);
    tri_set(8'h0F, SB);
    wr(tdm_loop_pkg::OFS_ACCESS_CTRL, 8'h50);
    idle();
    run(1, 5);
    cx(mk(DN, SA), DN, SS, tdm_loop_pkg::MODE_UNASSIGNED);
    cx(mk(LP, 8'h00), UP, SS, 4'h1);
    tri_set(8'h0F, 8'h00);
    tri_set(8'h05, SB);
    run(2, 5);
    cx(mk(UP, 8'h05), UP, 8'h02, 4'h1);
    cx(mk(UP, 8'h05), DN, SB, 4'h1);
    tri_set(8'h00, 8'h05);
    run(3, 5);
    for (int m = 2; m < 8; m++) begin
      cx(mk(DN, SA), DN, SS, 4'(m));
      run(4, 3);
    end
    print_verdict();
  end

  // watchdog: the whole sequence needs about 20000 cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule // tdm_slot_loop_switching_tb
